/* File: inc/asf_pkg.sv */
// Constants, encodings and field layout of the ALU and CPU status logic.
// Assumes one 100 MHz core clock and a 32-bit APB register bus.
package asf_pkg;

    // ------------------------------------------------------------------
    // Register indices; byte address is four times the index.
    // ------------------------------------------------------------------
    localparam logic [9:0] ALU_STA_IDX  = 10'h004;
    localparam logic [9:0] CPU_STA_IDX  = 10'h006;
    localparam logic [9:0] IRQ_STAT_IDX = 10'h008;
    localparam logic [9:0] IRQ_MASK_IDX = 10'h009;

    // ------------------------------------------------------------------
    // Field positions.
    // ------------------------------------------------------------------
    localparam int MODE_B_LSB = 6;
    localparam int MODE_A_LSB = 4;
    localparam int OV_BIT     = 3;
    localparam int Z_BIT      = 2;
    localparam int DC_BIT     = 1;
    localparam int C_BIT      = 0;
    localparam int STK_BIT    = 5;
    localparam int GID_BIT    = 4;
    localparam int TO_BIT     = 3;
    localparam int PD_BIT     = 2;
    localparam int IRQ_OV     = 0;
    localparam int IRQ_STK    = 1;
    localparam int IRQ_TO     = 2;
    localparam int IRQ_W      = 3;

    // ------------------------------------------------------------------
    // Reset values and masks.
    // ------------------------------------------------------------------
    localparam logic [7:0] ALU_STA_RST  = 8'hF0;
    localparam logic [7:0] CPU_STA_RST  = 8'h3C;
    localparam logic [7:0] CPU_WR_MASK  = 8'h10;
    localparam logic [3:0] AFF_ARITH    = 4'hF;
    localparam logic [3:0] AFF_ZERO     = 4'h4;
    localparam logic [3:0] AFF_CARRY    = 4'h1;
    localparam logic [3:0] AFF_NONE     = 4'h0;
    localparam logic [3:0] AFF_ZDCC     = 4'h7;

    typedef enum logic [1:0] {
        PTR_POST_DEC = 2'b00,
        PTR_POST_INC = 2'b01
    } asf_ptr_mode_e;

    typedef enum logic [3:0] {
        OP_ADD  = 4'h0,
        OP_SUB  = 4'h1,
        OP_AND  = 4'h2,
        OP_OR   = 4'h3,
        OP_XOR  = 4'h4,
        OP_INC  = 4'h5,
        OP_DEC  = 4'h6,
        OP_CLR  = 4'h7,
        OP_RLC  = 4'h8,
        OP_RRC  = 4'h9,
        OP_SWAP = 4'hA,
        OP_MOVE = 4'hB
    } asf_op_e;

endpackage : asf_pkg

/* File: rtl/asf_core.sv */
// ALU status flags, indirect pointer modes and CPU status of the core.
// Assumes the execution core drives op and write requests on clk and an
// APB master reaches the registers; the master reset pin is asynchronous.
//
// Operation
// - Flag-affecting op writing ALU status keeps logic-computed Z, DC, C.
// - Clearing ALU status zeroes mode bits, sets Z, keeps OV, DC, C.
// - Subtraction carry and digit carry read one when no borrow.
// - Overflow bit 3 set when signed result leaves -128..+127.
// - Overflow means magnitude carry flipped the sign bit 7.
// - Single ops use accumulator or file; dual ops add file or literal.
// - Bits 7-6 select post-decrement, post-increment or hold for pointer B.
// - Bits 5-4 select post-decrement, post-increment or hold for pointer A.
// - Zero bit 2 follows whether the result equals zero.
// - Addition digit carry bit 1 is carry out of bit 3.
// - Addition carry bit 0 is carry out of bit 7.
// - Subtraction adds the two's complement of the subtrahend.
// - Rotate through carry loads carry with the bit shifted out.
// - Time-out, power-down and stack bits ignore instruction writes.
// - CPU status holds the global interrupt disable control.
// - Master reset leaves time-out and power-down bits unchanged.
// - Pointer post-modify never touches any ALU flag.
module asf_core (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        extResetPinN,
    input  wire logic        opValid,
    input  wire logic [3:0]  opCode,
    input  wire logic [7:0]  accIn,
    input  wire logic [7:0]  fileIn,
    input  wire logic [7:0]  immIn,
    input  wire logic        srcFile,
    input  wire logic        useImm,
    input  wire logic        destAlu,
    input  wire logic        cpuWrite,
    input  wire logic [7:0]  cpuWdata,
    input  wire logic        stackAvailIn,
    input  wire logic        toLoad,
    input  wire logic        toIn,
    input  wire logic        pdLoad,
    input  wire logic        pdIn,
    input  wire logic        ptrReq,
    input  wire logic        ptrSelB,
    input  wire logic [7:0]  ptrIn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic      [7:0]  resultQ,
    output logic             resultValidQ,
    output logic      [7:0]  aluStaQ,
    output logic      [7:0]  cpuStaQ,
    output logic      [7:0]  ptrOutQ,
    output logic             ptrValidQ,
    output logic             irq
);

    // ------------------------------------------------------------------
    // Helpers.
    // ------------------------------------------------------------------
    // Returns {carry, digit carry, sum}.
    function automatic logic [9:0] asfAdd(input logic [7:0] a,
                                          input logic [7:0] b,
                                          input logic       cin);
        logic [4:0] lo;
        logic [8:0] full;
        lo   = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
        return {full[8], lo[4], full[7:0]};
    endfunction : asfAdd

    function automatic logic [3:0] asfAffects(input logic [3:0] op);
        case (op)
            asf_pkg::OP_ADD, asf_pkg::OP_SUB,
            asf_pkg::OP_INC, asf_pkg::OP_DEC: return asf_pkg::AFF_ARITH;
            asf_pkg::OP_AND, asf_pkg::OP_OR,
            asf_pkg::OP_XOR, asf_pkg::OP_CLR: return asf_pkg::AFF_ZERO;
            asf_pkg::OP_RLC, asf_pkg::OP_RRC: return asf_pkg::AFF_CARRY;
            default:                          return asf_pkg::AFF_NONE;
        endcase
    endfunction : asfAffects

    function automatic logic [7:0] asfPtrNext(input logic [1:0] mode,
                                              input logic [7:0] ptr);
        case (mode)
            asf_pkg::PTR_POST_DEC: return ptr - 8'h01;
            asf_pkg::PTR_POST_INC: return ptr + 8'h01;
            default:               return ptr;
        endcase
    endfunction : asfPtrNext

    // ------------------------------------------------------------------
    // Master reset pin synchroniser.
    // ------------------------------------------------------------------
    logic mclrMetaQ;
    logic mclrSyncQ;
    logic mclrActive;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mclrMetaQ <= 1'b1;
            mclrSyncQ <= 1'b1;
        end else begin
            mclrMetaQ <= extResetPinN;
            mclrSyncQ <= mclrMetaQ;
        end
    end

    assign mclrActive = !mclrSyncQ;

    // ------------------------------------------------------------------
    // Operand selection and ALU.
    // ------------------------------------------------------------------
    logic [7:0] opA;
    logic [7:0] opB;
    logic [7:0] adA;
    logic [7:0] adB;
    logic       adCin;
    logic [9:0] adSum;
    logic [7:0] result;
    logic [3:0] newFlags;
    logic [3:0] aff;
    logic [3:0] mergedFlags;

    // Dual ops pair the accumulator with a file or a literal.
    assign opA = srcFile ? fileIn : accIn;
    assign opB = useImm ? immIn : fileIn;

    always_comb begin
        adA   = accIn;
        adB   = opB;
        adCin = 1'b0;
        case (opCode)
            asf_pkg::OP_SUB: begin
                // Borrow shows as carry low because the add is a true add.
                adA   = opB;
                adB   = ~accIn;
                adCin = 1'b1;
            end
            asf_pkg::OP_INC: begin
                adA   = opA;
                adB   = 8'h00;
                adCin = 1'b1;
            end
            asf_pkg::OP_DEC: begin
                adA   = opA;
                adB   = 8'hFF;
            end
            default: begin
            end
        endcase
    end

    assign adSum = asfAdd(adA, adB, adCin);

    always_comb begin
        result   = adSum[7:0];
        newFlags = aluStaQ[3:0];
        newFlags[asf_pkg::C_BIT]  = adSum[9];
        newFlags[asf_pkg::DC_BIT] = adSum[8];
        // Same operand signs and a different result sign is overflow.
        newFlags[asf_pkg::OV_BIT] = (adA[7] == adB[7]) && (adSum[7] != adA[7]);
        case (opCode)
            asf_pkg::OP_AND:  result = accIn & opB;
            asf_pkg::OP_OR:   result = accIn | opB;
            asf_pkg::OP_XOR:  result = accIn ^ opB;
            asf_pkg::OP_CLR:  result = 8'h00;
            asf_pkg::OP_RLC: begin
                result = {opA[6:0], aluStaQ[asf_pkg::C_BIT]};
                newFlags[asf_pkg::C_BIT] = opA[7];
            end
            asf_pkg::OP_RRC: begin
                result = {aluStaQ[asf_pkg::C_BIT], opA[7:1]};
                newFlags[asf_pkg::C_BIT] = opA[0];
            end
            asf_pkg::OP_SWAP: result = {opA[3:0], opA[7:4]};
            asf_pkg::OP_MOVE: result = opB;
            default: begin
            end
        endcase
        newFlags[asf_pkg::Z_BIT] = (result == 8'h00);
    end

    assign aff         = asfAffects(opCode);
    assign mergedFlags = (newFlags & aff) | (aluStaQ[3:0] & ~aff);

    // ------------------------------------------------------------------
    // APB decode.
    // ------------------------------------------------------------------
    logic       apbAccess;
    logic       apbDone;
    logic       hitAlu;
    logic       hitCpu;
    logic       hitStat;
    logic       hitMask;
    logic       hitAny;
    logic [7:0] rdData;

    assign apbAccess = psel && penable;
    // Ready is registered, so every access phase lasts two cycles.
    assign apbDone   = apbAccess && pready;

    always_comb begin
        hitAlu  = 1'b0;
        hitCpu  = 1'b0;
        hitStat = 1'b0;
        hitMask = 1'b0;
        if (paddr == {asf_pkg::ALU_STA_IDX, 2'b00}) begin
            hitAlu = 1'b1;
        end else if (paddr == {asf_pkg::CPU_STA_IDX, 2'b00}) begin
            hitCpu = 1'b1;
        end else if (paddr == {asf_pkg::IRQ_STAT_IDX, 2'b00}) begin
            hitStat = 1'b1;
        end else if (paddr == {asf_pkg::IRQ_MASK_IDX, 2'b00}) begin
            hitMask = 1'b1;
        end
    end

    assign hitAny = hitAlu || hitCpu || hitStat || hitMask;

    logic [asf_pkg::IRQ_W-1:0] irqStatQ;
    logic [asf_pkg::IRQ_W-1:0] irqStatD;
    logic [asf_pkg::IRQ_W-1:0] irqMaskQ;

    always_comb begin
        rdData = 8'h00;
        if (hitAlu) begin
            rdData = aluStaQ;
        end else if (hitCpu) begin
            rdData = cpuStaQ;
        end else if (hitStat) begin
            rdData = {5'h00, irqStatQ};
        end else if (hitMask) begin
            rdData = {5'h00, irqMaskQ};
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= apbAccess && !pready;
            pslverr <= apbAccess && !pready && !hitAny;
            prdata  <= (apbAccess && !pready && !pwrite) ? {24'h000000, rdData} : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------------
    // ALU status register and result write-back.
    // ------------------------------------------------------------------
    logic [7:0] aluStaD;

    always_comb begin
        aluStaD = aluStaQ;
        if (opValid) begin
            if (destAlu) begin
                aluStaD = result;
                if ((aff & asf_pkg::AFF_ZDCC) != 4'h0) begin
                    // Destination data loses to the flag logic.
                    aluStaD[3:0] = mergedFlags;
                end
            end else begin
                aluStaD[3:0] = mergedFlags;
            end
        end else if (apbDone && pwrite && hitAlu) begin
            aluStaD = pwdata[7:0];
        end
        // Pointer post-modify is deliberately absent here.
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            aluStaQ <= asf_pkg::ALU_STA_RST;
        end else if (mclrActive) begin
            aluStaQ <= {asf_pkg::ALU_STA_RST[7:4], aluStaQ[3:0]};
        end else begin
            aluStaQ <= aluStaD;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            resultQ      <= 8'h00;
            resultValidQ <= 1'b0;
        end else begin
            resultQ      <= opValid ? result : resultQ;
            resultValidQ <= opValid;
        end
    end

    // ------------------------------------------------------------------
    // Indirect pointer post-modify.
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ptrOutQ   <= 8'h00;
            ptrValidQ <= 1'b0;
        end else begin
            ptrValidQ <= ptrReq;
            if (ptrReq) begin
                ptrOutQ <= ptrSelB
                    ? asfPtrNext(aluStaQ[asf_pkg::MODE_B_LSB +: 2], ptrIn)
                    : asfPtrNext(aluStaQ[asf_pkg::MODE_A_LSB +: 2], ptrIn);
            end
        end
    end

    // ------------------------------------------------------------------
    // CPU status register.
    // ------------------------------------------------------------------
    logic [7:0] cpuStaD;

    always_comb begin
        cpuStaD = cpuStaQ;
        if (cpuWrite) begin
            cpuStaD[asf_pkg::GID_BIT] = cpuWdata[asf_pkg::GID_BIT];
        end else if (apbDone && pwrite && hitCpu) begin
            cpuStaD = (cpuStaQ & ~asf_pkg::CPU_WR_MASK) | (pwdata[7:0] & asf_pkg::CPU_WR_MASK);
        end
        cpuStaD[asf_pkg::STK_BIT] = stackAvailIn;
        if (toLoad) begin
            cpuStaD[asf_pkg::TO_BIT] = toIn;
        end
        if (pdLoad) begin
            cpuStaD[asf_pkg::PD_BIT] = pdIn;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cpuStaQ <= asf_pkg::CPU_STA_RST;
        end else if (mclrActive) begin
            // Time-out and power-down survive so software can tell the cause.
            cpuStaQ <= (asf_pkg::CPU_STA_RST & 8'hF3) | (cpuStaQ & 8'h0C);
        end else begin
            cpuStaQ <= cpuStaD;
        end
    end

    // ------------------------------------------------------------------
    // Interrupt status and mask.
    // ------------------------------------------------------------------
    logic [asf_pkg::IRQ_W-1:0] irqEvent;

    assign irqEvent[asf_pkg::IRQ_OV]  = opValid && aff[asf_pkg::OV_BIT]
                                        && newFlags[asf_pkg::OV_BIT];
    assign irqEvent[asf_pkg::IRQ_STK] = cpuStaQ[asf_pkg::STK_BIT] && !stackAvailIn;
    assign irqEvent[asf_pkg::IRQ_TO]  = toLoad && !toIn && cpuStaQ[asf_pkg::TO_BIT];

    always_comb begin
        irqStatD = irqStatQ;
        if (apbDone && !pwrite && hitStat) begin
            irqStatD = '0;
        end
        // A new event wins over the read that clears.
        irqStatD = irqStatD | irqEvent;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irqStatQ <= '0;
            irqMaskQ <= '0;
            irq      <= 1'b0;
        end else begin
            irqStatQ <= irqStatD;
            if (apbDone && pwrite && hitMask) begin
                irqMaskQ <= pwdata[asf_pkg::IRQ_W-1:0];
            end
            irq <= |(irqStatD & irqMaskQ);
        end
    end

    // ------------------------------------------------------------------
    // Assertions.
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n || mclrActive);

    logic signed [8:0] sSum;
    logic        [8:0] uSum;
    assign sSum = $signed({accIn[7], accIn}) + $signed({opB[7], opB});
    assign uSum = {1'b0, accIn} + {1'b0, opB};

    property p_keep_carry;
        opValid && destAlu && opCode == asf_pkg::OP_AND
        |=> aluStaQ[1:0] == $past(aluStaQ[1:0]);
    endproperty
    a_keep_carry: assert property (p_keep_carry) else $error("flag write not blocked");

    property p_clear_alu;
        opValid && destAlu && opCode == asf_pkg::OP_CLR
        |=> aluStaQ[7:4] == 4'h0 && aluStaQ[2] && aluStaQ[3] == $past(aluStaQ[3])
            && aluStaQ[1:0] == $past(aluStaQ[1:0]);
    endproperty
    a_clear_alu: assert property (p_clear_alu) else $error("clear of status wrong");

    property p_borrow;
        opValid && !destAlu && opCode == asf_pkg::OP_SUB
        |=> aluStaQ[0] == ($past(opB) >= $past(accIn));
    endproperty
    a_borrow: assert property (p_borrow) else $error("borrow polarity wrong");

    property p_overflow;
        opValid && !destAlu && opCode == asf_pkg::OP_ADD
        |=> aluStaQ[3] == ($past(sSum) > 127 || $past(sSum) < -128);
    endproperty
    a_overflow: assert property (p_overflow) else $error("overflow flag wrong");

    property p_zero;
        opValid && !destAlu && aff[2]
        |=> aluStaQ[2] == (resultQ == 8'h00) && resultValidQ;
    endproperty
    a_zero: assert property (p_zero) else $error("zero flag wrong");

    property p_add_carry;
        opValid && !destAlu && opCode == asf_pkg::OP_ADD
        |=> aluStaQ[0] == $past(uSum[8])
            && aluStaQ[1] == ($past(accIn[3:0]) + $past(opB[3:0]) > 15);
    endproperty
    a_add_carry: assert property (p_add_carry) else $error("add carry wrong");

    property p_rotate;
        opValid && !destAlu && opCode == asf_pkg::OP_RLC
        |=> aluStaQ[0] == $past(opA[7]);
    endproperty
    a_rotate: assert property (p_rotate) else $error("rotate carry wrong");

    property p_cpu_protect;
        cpuWrite && !toLoad && !pdLoad
        |=> cpuStaQ[3:2] == $past(cpuStaQ[3:2])
            && cpuStaQ[4] == $past(cpuWdata[4]);
    endproperty
    a_cpu_protect: assert property (p_cpu_protect) else $error("protected bit written");

    property p_external_master_reset_keep;
        @(posedge clk) disable iff (!rst_n)
        mclrActive |=> cpuStaQ[3:2] == $past(cpuStaQ[3:2]);
    endproperty
    a_external_master_reset_keep: assert property (p_external_master_reset_keep) else $error("master reset lost state");

    property p_ptr_inc;
        ptrReq && !ptrSelB && aluStaQ[5:4] == 2'b01
        |=> ptrValidQ && ptrOutQ == $past(ptrIn) + 8'h01;
    endproperty
    a_ptr_inc: assert property (p_ptr_inc) else $error("pointer A step wrong");

    property p_ptr_b_hold;
        ptrReq && ptrSelB && aluStaQ[7]
        |=> ptrOutQ == $past(ptrIn);
    endproperty
    a_ptr_b_hold: assert property (p_ptr_b_hold) else $error("pointer B moved");

    property p_ptr_no_flags;
        ptrReq && !opValid && !apbAccess
        |=> aluStaQ[3:0] == $past(aluStaQ[3:0]);
    endproperty
    a_ptr_no_flags: assert property (p_ptr_no_flags) else $error("pointer touched flags");

    property p_move_all;
        opValid && destAlu && opCode == asf_pkg::OP_MOVE
        |=> aluStaQ == $past(opB);
    endproperty
    a_move_all: assert property (p_move_all) else $error("plain write not stored");

endmodule : asf_core

/* File: tb/asf_exec_model.sv */
// Stand-in for the instruction execution core that feeds ALU operations.
// Assumes the bench calls issue from one thread, clocked by clk.
module asf_exec_model (
    input  wire logic       clk,
    output logic            opValid,
    output logic      [3:0] opCode,
    output logic      [7:0] accIn,
    output logic      [7:0] fileIn,
    output logic      [7:0] immIn,
    output logic            srcFile,
    output logic            useImm,
    output logic            destAlu
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        {opValid, opCode, accIn, fileIn, immIn, srcFile, useImm, destAlu} = '0;
    end

    // Operands flip once the request is gone, so stale values never look valid.
    task automatic issue(input logic [3:0] c, input logic [7:0] a, f, i,
                         input logic s, u, d);
        @(posedge clk);
        {opValid, opCode, accIn, fileIn, immIn} <= {1'h1, c, a, f, i};
        {srcFile, useImm, destAlu} <= {s, u, d};
        @(posedge clk);
        {opValid, accIn, fileIn, immIn} <= {1'h0, ~a, ~f, ~i};
        #1;
    endtask : issue
endmodule : asf_exec_model

/* File: tb/alu_status_flags_tb.sv */
// Self-checking bench for the ALU and CPU status block.
// Assumes asf_pkg and asf_core are compiled before it.
`define CHK(nm, ex, gt) begin testsRun++; if ((gt) !== (ex)) begin failures++; \
    $display("wrong value %s expected %0h seen %0h", nm, ex, gt); end end
module alu_status_flags_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [11:0] AALU = {asf_pkg::ALU_STA_IDX, 2'h0};
    localparam logic [11:0] ACPU = {asf_pkg::CPU_STA_IDX, 2'h0};
    localparam logic [11:0] AIRQ = {asf_pkg::IRQ_STAT_IDX, 2'h0};
    localparam logic [11:0] AMSK = {asf_pkg::IRQ_MASK_IDX, 2'h0};
    logic        clk, rst_n, extResetPinN, cpuWrite, stackAvailIn, toLoad, toIn;
    logic        pdLoad, pdIn, ptrReq, ptrSelB, psel, penable, pwrite, err;
    logic        pready, pslverr, resultValidQ, ptrValidQ, irq, opValid;
    logic        srcFile, useImm, destAlu;
    logic [3:0]  opCode;
    logic [7:0]  cpuWdata, ptrIn, resultQ, aluStaQ, cpuStaQ, ptrOutQ;
    logic [7:0]  accIn, fileIn, immIn;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    int          failures, testsRun;

    asf_core asf_core_inst (.clk, .rst_n, .extResetPinN, .opValid, .opCode, .accIn,
        .fileIn, .immIn, .srcFile, .useImm, .destAlu, .cpuWrite, .cpuWdata,
        .stackAvailIn, .toLoad, .toIn, .pdLoad, .pdIn, .ptrReq, .ptrSelB, .ptrIn,
        .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .resultQ, .resultValidQ, .aluStaQ, .cpuStaQ, .ptrOutQ, .ptrValidQ, .irq);
    asf_exec_model asf_exec_model_inst (.clk, .opValid, .opCode, .accIn, .fileIn,
        .immIn, .srcFile, .useImm, .destAlu);

    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'h1, 1'h0, w, a, d};
        @(posedge clk);
        penable <= 1'h1;
        // Only pready or the watchdog may end this wait; the slave sets the pace.
        do begin
            @(posedge clk);
        end while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'h0;
    endtask : apb

    task automatic op(input logic [3:0] c, input logic [7:0] a, f, i,
                      input logic s, u, d, input logic [7:0] er, ea);
        asf_exec_model_inst.issue(c, a, f, i, s, u, d);
        `CHK("result", er, resultQ)
        `CHK("alu", ea, aluStaQ)
        `CHK("valid", 1'h1, resultValidQ)
    endtask : op

    task automatic ptr(input logic b, input logic [7:0] v, e, ea);
        @(posedge clk);
        {ptrReq, ptrSelB, ptrIn} <= {1'h1, b, v};
        @(posedge clk);
        {ptrReq, ptrIn} <= {1'h0, ~v};
        #1;
        `CHK("pointer", e, ptrOutQ)
        `CHK("alu", ea, aluStaQ)
    endtask : ptr

    task automatic cpu(input logic [7:0] d, e);
        @(posedge clk);
        {cpuWrite, cpuWdata} <= {1'h1, d};
        @(posedge clk);
        cpuWrite <= 1'h0;
        #1;
        `CHK("cpu", e, cpuStaQ)
    endtask : cpu

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", testsRun, failures);
        if (failures == 0 && testsRun > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : tally_and_finish

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        apb(1'h0, AALU, 32'h0);
        `CHK("alu reset", 32'h000000F0, rd)
        apb(1'h0, ACPU, 32'h0);
        `CHK("cpu reset", 32'h0000003C, rd)
        apb(1'h0, 12'h0FC, 32'h0);
        `CHK("unmapped", 1'h1, err)
    endtask : t_reset

    task automatic t_alu();
        op(asf_pkg::OP_ADD, 8'h7F, 8'h01, 8'h00, 0, 0, 0, 8'h80, 8'hFA);
        op(asf_pkg::OP_ADD, 8'hFF, 8'h00, 8'h01, 0, 1, 0, 8'h00, 8'hF7);
        op(asf_pkg::OP_SUB, 8'h05, 8'h03, 8'h00, 0, 0, 0, 8'hFE, 8'hF0);
        op(asf_pkg::OP_SUB, 8'h03, 8'h05, 8'h00, 0, 0, 0, 8'h02, 8'hF3);
        op(asf_pkg::OP_SUB, 8'h01, 8'h80, 8'h00, 0, 0, 0, 8'h7F, 8'hF9);
        op(asf_pkg::OP_RLC, 8'h00, 8'h01, 8'h00, 1, 0, 0, 8'h03, 8'hF8);
        op(asf_pkg::OP_RRC, 8'h01, 8'h00, 8'h00, 0, 0, 0, 8'h00, 8'hF9);
        op(asf_pkg::OP_AND, 8'h0F, 8'hF0, 8'h00, 0, 0, 0, 8'h00, 8'hFD);
        op(asf_pkg::OP_CLR, 8'h00, 8'h55, 8'h00, 1, 0, 1, 8'h00, 8'h0D);
        op(asf_pkg::OP_ADD, 8'h01, 8'h01, 8'h00, 0, 0, 1, 8'h02, 8'h00);
        op(asf_pkg::OP_MOVE, 8'hA5, 8'hA5, 8'h00, 0, 0, 1, 8'hA5, 8'hA5);
        op(asf_pkg::OP_AND, 8'hF3, 8'hF3, 8'h00, 0, 0, 1, 8'hF3, 8'hF1);
    endtask : t_alu

    task automatic t_ptr_cpu();
        apb(1'h1, AALU, 32'h10);
        ptr(1'h1, 8'h01, 8'h00, 8'h10);
        ptr(1'h0, 8'hFF, 8'h00, 8'h10);
        apb(1'h1, AALU, 32'hA0);
        ptr(1'h1, 8'h33, 8'h33, 8'hA0);
        ptr(1'h0, 8'h33, 8'h33, 8'hA0);
        cpu(8'h00, 8'h2C);
        cpu(8'hFF, 8'h3C);
        apb(1'h1, ACPU, 32'h0);
        apb(1'h0, ACPU, 32'h0);
        `CHK("cpu apb", 32'h0000002C, rd)
    endtask : t_ptr_cpu

    task automatic t_ext_irq();
        @(posedge clk);
        // Time-out and power-down load low and the stack flag falls together.
        {toLoad, toIn, pdLoad, pdIn, stackAvailIn} <= 5'h14;
        @(posedge clk);
        {toLoad, pdLoad} <= 2'h0;
        extResetPinN <= 1'h0;
        repeat (5) @(posedge clk);
        #1;
        `CHK("cpu ext", 8'h30, cpuStaQ)
        `CHK("alu ext", 8'hF0, aluStaQ)
        `CHK("irq masked", 1'h0, irq)
        @(posedge clk);
        extResetPinN <= 1'h1;
        repeat (4) @(posedge clk);
        apb(1'h0, AIRQ, 32'h0);
        `CHK("irq status", 32'h7, rd)
        apb(1'h1, AMSK, 32'h1);
        op(asf_pkg::OP_ADD, 8'h7F, 8'h01, 8'h00, 0, 0, 0, 8'h80, 8'hFA);
        repeat (2) @(posedge clk);
        #1;
        `CHK("irq set", 1'h1, irq)
        apb(1'h0, AIRQ, 32'h0);
        `CHK("irq ov", 32'h1, rd)
        repeat (2) @(posedge clk);
        #1;
        `CHK("irq clear", 1'h0, irq)
    endtask : t_ext_irq

    initial begin
        {rst_n, cpuWrite, toLoad, toIn, pdLoad, pdIn, ptrReq, ptrSelB} = '0;
        {psel, penable, pwrite, cpuWdata, ptrIn, paddr, pwdata} = '0;
        {extResetPinN, stackAvailIn} = 2'h3;
        failures = 0;
        testsRun = 0;
        repeat (6) @(posedge clk);
        rst_n <= 1'h1;
        t_reset();
        t_alu();
        t_ptr_cpu();
        t_ext_irq();
        tally_and_finish();
    end

    // A hung handshake would otherwise stall the run forever.
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        tally_and_finish();
    end
endmodule : alu_status_flags_tb
